// file: hdl/vlx_exit_check.sv
// Virtual legacy mode state, sensitive-instruction checks and exit control.
// Assumes a decoder handing one instruction per cycle and a register port master.
`timescale 1ns/10ps
module vlx_exit_check (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // External sources
   input wire logic resetReq,
   input wire logic warmReq,
   input wire logic hwIntReq,
   input wire logic [7:0] hwIntVec,
   input wire logic hwIntTaskGate,
   // Instruction and flags-image loads
   input wire vlx_pkg::vlx_instr_t instr,
   input wire vlx_pkg::vlx_load_t flagsLoad,
   // Register port
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   // Results
   output vlx_pkg::vlx_event_t excEvent,
   output logic redirect,
   output logic [7:0] redirVec,
   output vlx_pkg::vlx_mode_t mode,
   output logic [1:0] current_privilege_level,
   output logic irq
);
   import vlx_pkg::*;

   vlx_state_t st_ff;
   vlx_state_t nxt_st;
   logic inVleg;
   logic [1:0] privField;
   logic extEn;
   logic sensitive;
   logic [NUM_STAT-1:0] setEv;
   logic instrSlot;

   assign inVleg = (st_ff.mode == VLX_MODE_VLEG);
   assign privField = st_ff.flags[PRIV_HI:PRIV_LO];
   assign extEn = st_ff.ctl4[EXT_BIT];
   assign instrSlot = !resetReq && !warmReq && !hwIntReq && !flagsLoad.valid;

   always_comb begin
      case (instr.op)
         VLX_OP_CLI, VLX_OP_STI, VLX_OP_PUSH_FLAGS_INSTR, VLX_OP_POP_FLAGS_INSTR, VLX_OP_SWINT, VLX_OP_INTERRUPT_RETURN_INSTR: sensitive = 1'b1;
         default: sensitive = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_st = st_ff;
      setEv = '0;
      nxt_st.evt = '0;
      nxt_st.redirect = 1'b0;
      nxt_st.rdata = '0;
      if (resetReq || warmReq) begin
         // Reset wins over interrupts, flags loads and instructions in flight
         nxt_st.mode = VLX_MODE_REAL;
         nxt_st.flags = FLAGS_RST;
         nxt_st.current_privilege_level = PRIV_KERNEL;
         if (inVleg) begin
            setEv[ST_EXIT] = 1'b1;
         end
      end else if (hwIntReq) begin
         nxt_st.evt.valid = 1'b1;
         nxt_st.evt.vec = hwIntVec;
         nxt_st.evt.savedIp = instr.ip;
         nxt_st.evt.isFault = 1'b0;
         nxt_st.evt.taskGate = hwIntTaskGate;
         if (st_ff.mode != VLX_MODE_REAL) begin
            nxt_st.mode = VLX_MODE_PROT;
            nxt_st.current_privilege_level = PRIV_KERNEL;
            nxt_st.flags[VLM_BIT] = 1'b0;
         end
         if (inVleg) begin
            setEv[ST_EXIT] = 1'b1;
         end
      end else if (flagsLoad.valid) begin
         // mode flag only from an image
         nxt_st.flags = flagsLoad.image;
         if (st_ff.mode == VLX_MODE_REAL) begin
            // A task switch needs protected mode, so the first load lands there
            nxt_st.mode = VLX_MODE_PROT;
         end else begin
            nxt_st.mode = flagsLoad.image[VLM_BIT] ? VLX_MODE_VLEG : VLX_MODE_PROT;
            nxt_st.current_privilege_level = flagsLoad.image[VLM_BIT] ? PRIV_USER : st_ff.current_privilege_level;
         end
      end else if (instr.valid && inVleg) begin
         if ((instr.op == VLX_OP_HALT) || (sensitive && (privField != PRIV_USER) &&
               !(instr.op == VLX_OP_SWINT && extEn && instr.redirAllowed))) begin
            nxt_st.evt.valid = 1'b1;
            nxt_st.evt.vec = VEC_GPF;
            nxt_st.evt.savedIp = instr.ip;
            nxt_st.evt.isFault = 1'b1;
            setEv[ST_GPF] = 1'b1;
         end else if (instr.op == VLX_OP_SWINT && extEn && instr.redirAllowed) begin
            nxt_st.redirect = 1'b1; // stays in the mode
            nxt_st.redirVec = instr.vec;
            setEv[ST_REDIR] = 1'b1;
         end else if (instr.op == VLX_OP_PORT && instr.portDenied) begin
            nxt_st.evt.valid = 1'b1; // bitmap always decides
            nxt_st.evt.vec = VEC_GPF;
            nxt_st.evt.savedIp = instr.ip;
            nxt_st.evt.isFault = 1'b1;
            setEv[ST_GPF] = 1'b1;
         end else if (instr.op == VLX_OP_MEM && !instr.pagePresent) begin
            nxt_st.evt.valid = 1'b1;
            nxt_st.evt.vec = VEC_PAGE;
            nxt_st.evt.savedIp = instr.ip;
            nxt_st.evt.isFault = 1'b1;
            setEv[ST_PAGE] = 1'b1;
         end else if (instr.op == VLX_OP_POP_FLAGS_INSTR) begin
            // Privilege field three here; the mode flag and field are kept
            nxt_st.flags = instr.popValue;
            nxt_st.flags[VLM_BIT] = st_ff.flags[VLM_BIT];
            nxt_st.flags[PRIV_HI:PRIV_LO] = privField;
         end
         if (nxt_st.evt.valid) begin
            nxt_st.mode = VLX_MODE_PROT;
            nxt_st.current_privilege_level = PRIV_KERNEL;
            nxt_st.flags[VLM_BIT] = 1'b0;
            setEv[ST_EXIT] = 1'b1;
         end
      end else if (instr.valid && st_ff.mode == VLX_MODE_PROT && instr.op == VLX_OP_MEM
            && !instr.pagePresent) begin
         nxt_st.evt.valid = 1'b1;
         nxt_st.evt.vec = VEC_PAGE;
         nxt_st.evt.savedIp = instr.ip;
         nxt_st.evt.isFault = 1'b1;
         setEv[ST_PAGE] = 1'b1;
      end
      // Register port; status is write-one-to-clear, a new event wins
      if (regWr) begin
         case (regAddr)
            REG_CTL4: nxt_st.ctl4 = regWdata;
            REG_STATUS: nxt_st.status = st_ff.status & ~regWdata[NUM_STAT-1:0];
            REG_MASK: nxt_st.mask = regWdata[NUM_STAT-1:0];
            default: ;
         endcase
      end
      nxt_st.status = nxt_st.status | setEv;
      if (regRd) begin
         case (regAddr)
            REG_FLAGS: nxt_st.rdata = st_ff.flags;
            REG_CTL4: nxt_st.rdata = st_ff.ctl4;
            REG_STATUS: nxt_st.rdata = {{(32-NUM_STAT){1'b0}}, st_ff.status};
            REG_MASK: nxt_st.rdata = {{(32-NUM_STAT){1'b0}}, st_ff.mask};
            default: nxt_st.rdata = '0;
         endcase
      end
      nxt_st.irq = |(nxt_st.status & nxt_st.mask);
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= '{mode: VLX_MODE_REAL, flags: FLAGS_RST, current_privilege_level: PRIV_KERNEL, default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign regRdata = st_ff.rdata;
   assign excEvent = st_ff.evt;
   assign redirect = st_ff.redirect;
   assign redirVec = st_ff.redirVec;
   assign mode = st_ff.mode;
   assign current_privilege_level = st_ff.current_privilege_level;
   assign irq = st_ff.irq;

   ////////////////////////////////////////////////////////////////////////////
   property p_cpl_three;
      @(posedge sys_clk) disable iff (!rstn) (st_ff.mode == VLX_MODE_VLEG) |-> (st_ff.current_privilege_level == PRIV_USER);
   endproperty
   a_cpl_three: assert property (p_cpl_three) else $error("cpl not three in mode");

   property p_halt_fault;
      @(posedge sys_clk) disable iff (!rstn)
         (inVleg && instr.valid && instr.op == VLX_OP_HALT && !resetReq && !warmReq && !hwIntReq && !flagsLoad.valid)
         |=> (st_ff.evt.valid && st_ff.evt.vec == VEC_GPF && st_ff.evt.savedIp == $past(instr.ip));
   endproperty
   a_halt_fault: assert property (p_halt_fault) else $error("halt did not fault");

   property p_reset_real;
      @(posedge sys_clk) disable iff (!rstn) (resetReq || warmReq) |=> (st_ff.mode == VLX_MODE_REAL);
   endproperty
   a_reset_real: assert property (p_reset_real) else $error("reset did not enter real mode");

   property p_exit_cause;
      @(posedge sys_clk) disable iff (!rstn)
         (inVleg && nxt_st.mode != VLX_MODE_VLEG) |-> (nxt_st.evt.valid || resetReq || warmReq || flagsLoad.valid);
   endproperty
   a_exit_cause: assert property (p_exit_cause) else $error("mode left without cause");

   property p_sens_fault;
      @(posedge sys_clk) disable iff (!rstn)
         (inVleg && instr.valid && sensitive && privField != PRIV_USER && instr.op != VLX_OP_SWINT
         && !resetReq && !warmReq && !hwIntReq && !flagsLoad.valid) |=> (st_ff.evt.valid && st_ff.evt.isFault);
   endproperty
   a_sens_fault: assert property (p_sens_fault) else $error("sensitive op did not fault");

   property p_port_no_priv;
      @(posedge sys_clk) disable iff (!rstn)
         (inVleg && instr.valid && instr.op == VLX_OP_PORT && !instr.portDenied && !hwIntReq
         && !resetReq && !warmReq && !flagsLoad.valid) |=> !st_ff.evt.valid;
   endproperty
   a_port_no_priv: assert property (p_port_no_priv) else $error("permitted port faulted");

   property p_port_bitmap;
      @(posedge sys_clk) disable iff (!rstn)
         (inVleg && instr.valid && instr.op == VLX_OP_PORT && instr.portDenied && !hwIntReq
         && !resetReq && !warmReq && !flagsLoad.valid) |=> (st_ff.evt.valid && st_ff.mode == VLX_MODE_PROT);
   endproperty
   a_port_bitmap: assert property (p_port_bitmap) else $error("denied port not trapped");

   property p_pop_flags_instr_keep;
      @(posedge sys_clk) disable iff (!rstn)
         (inVleg && instr.valid && instr.op == VLX_OP_POP_FLAGS_INSTR && privField == PRIV_USER && !flagsLoad.valid
         && !hwIntReq && !resetReq && !warmReq) |=> (st_ff.flags[VLM_BIT] == $past(st_ff.flags[VLM_BIT]));
   endproperty
   a_pop_flags_instr_keep: assert property (p_pop_flags_instr_keep) else $error("pop changed mode flag");

   property p_redirect_stay;
      @(posedge sys_clk) disable iff (!rstn)
         st_ff.redirect |-> (st_ff.mode == VLX_MODE_VLEG && st_ff.ctl4[EXT_BIT]);
   endproperty
   a_redirect_stay: assert property (p_redirect_stay) else $error("redirect left mode");

   property p_hw_exit;
      @(posedge sys_clk) disable iff (!rstn)
         (inVleg && hwIntReq && !resetReq && !warmReq)
         |=> (st_ff.mode == VLX_MODE_PROT && st_ff.current_privilege_level == PRIV_KERNEL && !st_ff.flags[VLM_BIT]);
   endproperty
   a_hw_exit: assert property (p_hw_exit) else $error("interrupt did not leave mode");

   property p_hw_report;
      @(posedge sys_clk) disable iff (!rstn)
         (hwIntReq && !resetReq && !warmReq)
         |=> (st_ff.evt.valid && st_ff.evt.vec == $past(hwIntVec) && st_ff.evt.taskGate == $past(hwIntTaskGate));
   endproperty
   a_hw_report: assert property (p_hw_report) else $error("interrupt not reported");

   property p_load_mode;
      @(posedge sys_clk) disable iff (!rstn)
         (flagsLoad.valid && !resetReq && !warmReq && !hwIntReq && st_ff.mode != VLX_MODE_REAL)
         |=> ((st_ff.mode == VLX_MODE_VLEG) == $past(flagsLoad.image[VLM_BIT]));
   endproperty
   a_load_mode: assert property (p_load_mode) else $error("loaded mode flag ignored");

   property p_load_flags;
      @(posedge sys_clk) disable iff (!rstn)
         (flagsLoad.valid && !resetReq && !warmReq && !hwIntReq)
         |=> (st_ff.flags == $past(flagsLoad.image));
   endproperty
   a_load_flags: assert property (p_load_flags) else $error("flags image not loaded");

   property p_exit_kernel;
      @(posedge sys_clk) disable iff (!rstn)
         (inVleg && nxt_st.evt.valid)
         |=> (st_ff.mode == VLX_MODE_PROT && st_ff.current_privilege_level == PRIV_KERNEL && !st_ff.flags[VLM_BIT]);
   endproperty
   a_exit_kernel: assert property (p_exit_kernel) else $error("event not handled in protected mode");

   property p_swint_fault;
      @(posedge sys_clk) disable iff (!rstn)
         (inVleg && instrSlot && instr.valid && instr.op == VLX_OP_SWINT && privField != PRIV_USER
         && !(extEn && instr.redirAllowed)) |=> (st_ff.evt.valid && st_ff.evt.vec == VEC_GPF);
   endproperty
   a_swint_fault: assert property (p_swint_fault) else $error("soft int did not fault");

   property p_redirect_take;
      @(posedge sys_clk) disable iff (!rstn)
         (inVleg && instrSlot && instr.valid && instr.op == VLX_OP_SWINT && extEn && instr.redirAllowed)
         |=> (st_ff.redirect && st_ff.redirVec == $past(instr.vec) && st_ff.mode == VLX_MODE_VLEG);
   endproperty
   a_redirect_take: assert property (p_redirect_take) else $error("soft int not redirected");

   property p_exit_flag;
      @(posedge sys_clk) disable iff (!rstn)
         (inVleg && (resetReq || warmReq))
         |=> (st_ff.status[ST_EXIT] && st_ff.current_privilege_level == PRIV_KERNEL && st_ff.flags == FLAGS_RST);
   endproperty
   a_exit_flag: assert property (p_exit_flag) else $error("restart exit not flagged");

   property p_halt_status;
      @(posedge sys_clk) disable iff (!rstn)
         (inVleg && instrSlot && instr.valid && instr.op == VLX_OP_HALT)
         |=> (st_ff.status[ST_GPF] && st_ff.status[ST_EXIT] && st_ff.mode == VLX_MODE_PROT);
   endproperty
   a_halt_status: assert property (p_halt_status) else $error("halt fault not flagged");

   property p_sens_pass;
      @(posedge sys_clk) disable iff (!rstn)
         (inVleg && instrSlot && instr.valid && sensitive && instr.op != VLX_OP_SWINT && privField == PRIV_USER)
         |=> (!st_ff.evt.valid && st_ff.mode == VLX_MODE_VLEG);
   endproperty
   a_sens_pass: assert property (p_sens_pass) else $error("sensitive op faulted at full field");

   property p_sens_ip;
      @(posedge sys_clk) disable iff (!rstn)
         (inVleg && instrSlot && instr.valid && sensitive && instr.op != VLX_OP_SWINT && privField != PRIV_USER)
         |=> (st_ff.evt.isFault && st_ff.evt.savedIp == $past(instr.ip) && st_ff.evt.vec == VEC_GPF);
   endproperty
   a_sens_ip: assert property (p_sens_ip) else $error("fault ip not the instruction");

   property p_real_cpl;
      @(posedge sys_clk) disable iff (!rstn)
         (st_ff.mode == VLX_MODE_REAL)
         |-> (st_ff.current_privilege_level == PRIV_KERNEL);
   endproperty
   a_real_cpl: assert property (p_real_cpl) else $error("real mode not at level zero");

   property p_sens_status;
      @(posedge sys_clk) disable iff (!rstn)
         (inVleg && instrSlot && instr.valid && sensitive && instr.op != VLX_OP_SWINT && privField != PRIV_USER)
         |=> (st_ff.status[ST_GPF] && st_ff.mode == VLX_MODE_PROT && st_ff.current_privilege_level == PRIV_KERNEL);
   endproperty
   a_sens_status: assert property (p_sens_status) else $error("sensitive fault not flagged");

   property p_page_fault;
      @(posedge sys_clk) disable iff (!rstn)
         (st_ff.mode != VLX_MODE_REAL && instrSlot && instr.valid && instr.op == VLX_OP_MEM && !instr.pagePresent)
         |=> (st_ff.evt.valid && st_ff.evt.vec == VEC_PAGE && st_ff.status[ST_PAGE]);
   endproperty
   a_page_fault: assert property (p_page_fault) else $error("missing page not trapped");

   property p_pop_flags_instr_field;
      @(posedge sys_clk) disable iff (!rstn)
         (inVleg && instrSlot && instr.valid && instr.op == VLX_OP_POP_FLAGS_INSTR && privField == PRIV_USER)
         |=> (st_ff.flags[PRIV_HI:PRIV_LO] == PRIV_USER);
   endproperty
   a_pop_flags_instr_field: assert property (p_pop_flags_instr_field) else $error("pop changed privilege field");

   property p_ext_off;
      @(posedge sys_clk) disable iff (!rstn)
         (inVleg && instrSlot && instr.valid && instr.op == VLX_OP_SWINT && !extEn)
         |=> !st_ff.redirect;
   endproperty
   a_ext_off: assert property (p_ext_off) else $error("redirect without extension");

endmodule

// file: hdl/vlx_pkg.sv
// Constants and carrier types for the virtual legacy mode exit checker.
// Assumes one core clock and a decoder that presents one instruction per cycle.
//
// Notes on behaviour
// - The mode is left only because an interrupt or exception is taken, a restart occurs, or a flags image with the mode flag clear is loaded.
// - A suspending hardware interrupt enters protected mode, then switches tasks via gate.
// - A task switch loads the new flags word; outside real-address mode its mode flag picks the mode, from real mode it enters protected mode.
// - Task exceptions and its hardware interrupts go to protected vector handlers; return resumes.
// - Software interrupts in the mode raise a protection fault for the monitor when the privilege field is below three.
// - With the extension enabled, software interrupts with redirect allowed redirect to guest handlers in mode.
// - Reset or warm restart in the mode leaves it and enters real-address mode.
// - Halt in the mode raises a protection fault instead of halting.
// - Six instructions are privilege-field sensitive: cli, sti, push_flags_instr, pop_flags_instr, int, interrupt_return_instr.
// - Port reads and writes and string forms skip the privilege field check.
// - Current privilege level is held at three while in the mode.
// - Privilege field below three makes sensitive instructions raise a protection fault.
// - Port I/O in the mode always consults the task's permission bitmap.
// - Access to a not-present page raises an exception outside real-address mode.
// - The privilege field sits in flags word bits 12 and 13.
// - The extension enable is bit 0 of control register four.
// - A flag pop cannot change the mode flag; flags images, events taken outside real mode and restarts can.
package vlx_pkg;

   localparam int FLAGS_W = 32;
   localparam int PRIV_LO = 12;
   localparam int PRIV_HI = 13;
   localparam int VLM_BIT = 17;
   localparam int EXT_BIT = 0;
   localparam logic [1:0] PRIV_USER = 2'h3;
   localparam logic [1:0] PRIV_KERNEL = 2'h0;
   localparam logic [FLAGS_W-1:0] FLAGS_RST = 32'h0000_0002;
   localparam logic [7:0] VEC_GPF = 8'h0d;
   localparam logic [7:0] VEC_PAGE = 8'h0e;
   localparam int NUM_STAT = 4;
   localparam int ST_GPF = 0;
   localparam int ST_PAGE = 1;
   localparam int ST_EXIT = 2;
   localparam int ST_REDIR = 3;

   typedef enum logic [3:0] {
      VLX_OP_NONE,
      VLX_OP_CLI,
      VLX_OP_STI,
      VLX_OP_PUSH_FLAGS_INSTR,
      VLX_OP_POP_FLAGS_INSTR,
      VLX_OP_SWINT,
      VLX_OP_INTERRUPT_RETURN_INSTR,
      VLX_OP_HALT,
      VLX_OP_PORT,
      VLX_OP_MEM
   } vlx_op_t;

   typedef enum logic [1:0] {
      VLX_MODE_REAL,
      VLX_MODE_PROT,
      VLX_MODE_VLEG
   } vlx_mode_t;

   // One decoded instruction from the front end
   typedef struct packed {
      logic valid;
      vlx_op_t op;
      logic [31:0] ip;
      logic [7:0] vec;
      logic portDenied;
      logic pagePresent;
      logic redirAllowed;
      logic [FLAGS_W-1:0] popValue;
   } vlx_instr_t;

   // Task switch or handler return restoring a flags image
   typedef struct packed {
      logic valid;
      logic [FLAGS_W-1:0] image;
   } vlx_load_t;

   // Exception or handler entry report
   typedef struct packed {
      logic valid;
      logic [7:0] vec;
      logic [31:0] savedIp;
      logic isFault;
      logic taskGate;
   } vlx_event_t;

   typedef struct packed {
      vlx_mode_t mode;
      logic [FLAGS_W-1:0] flags;
      logic [1:0] current_privilege_level;
      logic [FLAGS_W-1:0] ctl4;
      logic [NUM_STAT-1:0] status;
      logic [NUM_STAT-1:0] mask;
      vlx_event_t evt;
      logic redirect;
      logic [7:0] redirVec;
      logic [31:0] rdata;
      logic irq;
   } vlx_state_t;

   localparam logic [3:0] REG_FLAGS = 4'h0;
   localparam logic [3:0] REG_CTL4 = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_MASK = 4'hc;

endpackage

// file: test/vlx_exit_check_tb.sv
// Self-checking bench for the virtual legacy mode exit checker.
// Assumes vlx_src_model drives the reset, warm and interrupt requests.
`timescale 1ns/10ps
module vlx_exit_check_tb;
   import vlx_pkg::*;
   typedef struct packed {
      vlx_op_t op;
      logic [1:0] io_privilege_field;
      logic [3:0] ctl;
      logic [7:0] vec;
   } vlx_row_t;
   logic sys_clk = 1'h0;
   logic rstn = 1'h0;
   logic resetReq, warmReq, hwIntReq, hwIntTaskGate, redirect, irq;
   logic [7:0] hwIntVec, redirVec;
   vlx_instr_t instr = '0;
   vlx_load_t flagsLoad = '0;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0;
   logic [31:0] regRdata;
   logic regWr = 1'h0;
   logic regRd = 1'h0;
   vlx_event_t excEvent;
   vlx_mode_t mode;
   logic [1:0] current_privilege_level;
   int miscompares = 0;
   int checks = 0;
   vlx_row_t rows[13];
   always #2 sys_clk = ~sys_clk;
   vlx_src_model i_src (.sys_clk(sys_clk), .resetReq(resetReq), .warmReq(warmReq), .hwIntReq(hwIntReq),
      .hwIntVec(hwIntVec), .hwIntTaskGate(hwIntTaskGate));
   vlx_exit_check i_dut (.sys_clk(sys_clk), .rstn(rstn), .resetReq(resetReq), .warmReq(warmReq),
      .hwIntReq(hwIntReq), .hwIntVec(hwIntVec), .hwIntTaskGate(hwIntTaskGate), .instr(instr),
      .flagsLoad(flagsLoad), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .excEvent(excEvent), .redirect(redirect), .redirVec(redirVec), .mode(mode),
      .current_privilege_level(current_privilege_level), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chkMode(input vlx_mode_t m, input logic [1:0] c);
      chk("mode", 48'(m), 48'(mode));
      chk("cpl", 48'(c), 48'(current_privilege_level));
   endtask
   task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'h1;
      @(posedge sys_clk);
      regWr <= 1'h0;
   endtask
   task automatic regRead(input logic [3:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      regAddr <= a;
      regRd <= 1'h1;
      @(posedge sys_clk);
      regRd <= 1'h0;
      #1 chk("regRdata", 48'(exp), 48'(regRdata));
   endtask
   task automatic doInstr(input vlx_op_t op, input logic [31:0] ip, input logic [3:0] ctl);
      @(posedge sys_clk);
      instr <= '{1'h1, op, ip, 8'h21, ctl[1], ctl[0], ctl[2], 32'h0000_0002};
      @(posedge sys_clk);
      instr.valid <= 1'h0;
      #1;
   endtask
   task automatic loadFlags(input logic [31:0] img);
      @(posedge sys_clk);
      flagsLoad <= '{1'h1, img};
      @(posedge sys_clk);
      flagsLoad.valid <= 1'h0;
      #1;
   endtask
   function automatic logic [31:0] vlImg(input logic [1:0] io_privilege_field);
      return {14'h0, 1'h1, 3'h0, io_privilege_field, 12'h002};
   endfunction
   // From real mode the first load only reaches protected mode
   task automatic enterVleg(input logic [1:0] io_privilege_field);
      loadFlags(vlImg(io_privilege_field));
      loadFlags(vlImg(io_privilege_field));
   endtask
   task automatic report_and_stop;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #20000;
      miscompares++;
      report_and_stop();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      // ctl is {extension, redirect allowed, port denied, page present}
      rows = '{'{VLX_OP_CLI, 2'h0, 4'h1, VEC_GPF},
         '{VLX_OP_STI, 2'h0, 4'h1, VEC_GPF},
         '{VLX_OP_PUSH_FLAGS_INSTR, 2'h0, 4'h1, VEC_GPF},
         '{VLX_OP_POP_FLAGS_INSTR, 2'h0, 4'h1, VEC_GPF},
         '{VLX_OP_INTERRUPT_RETURN_INSTR, 2'h0, 4'h1, VEC_GPF},
         '{VLX_OP_SWINT, 2'h0, 4'h1, VEC_GPF},
         '{VLX_OP_HALT, 2'h3, 4'h1, VEC_GPF},
         '{VLX_OP_CLI, 2'h3, 4'h1, 8'h00},
         '{VLX_OP_PORT, 2'h0, 4'h1, 8'h00},
         '{VLX_OP_PORT, 2'h3, 4'h3, VEC_GPF},
         '{VLX_OP_MEM, 2'h3, 4'h0, VEC_PAGE},
         '{VLX_OP_SWINT, 2'h0, 4'hd, 8'h00},
         '{VLX_OP_SWINT, 2'h3, 4'h1, 8'h00}};
      repeat (2) @(posedge sys_clk);
      rstn <= 1'h1;
      #1 chkMode(VLX_MODE_REAL, 2'h0);
      regWrite(REG_FLAGS, 32'hffff_ffff);
      regRead(REG_FLAGS, FLAGS_RST);
      regWrite(4'h2, 32'h5);
      regRead(4'h2, 32'h0);
      $display("test reset done");
      foreach (rows[i]) begin
         enterVleg(rows[i].io_privilege_field);
         chkMode(VLX_MODE_VLEG, PRIV_USER);
         regRead(REG_FLAGS, vlImg(rows[i].io_privilege_field));
         regWrite(REG_CTL4, {31'h0, rows[i].ctl[3]});
         doInstr(rows[i].op, 32'h100 + i, rows[i].ctl);
         chk("event", rows[i].vec == 8'h0 ? 48'h0 : {5'h0, 1'h1, rows[i].vec, 32'h100 + i, 2'h2},
            rows[i].vec == 8'h0 ? 48'(excEvent.valid) : 48'(excEvent));
         chk("redirect", {39'h0, rows[i].ctl[3], rows[i].ctl[3] ? 8'h21 : 8'h0},
            {39'h0, redirect, redirect ? redirVec : 8'h0});
         if (rows[i].vec != 8'h0) begin
            chkMode(VLX_MODE_PROT, PRIV_KERNEL);
         end else begin
            chkMode(VLX_MODE_VLEG, PRIV_USER);
         end
         regWrite(REG_STATUS, 32'hf);
      end
      $display("test table done");
      regWrite(REG_CTL4, 32'h0);
      enterVleg(2'h3);
      doInstr(VLX_OP_HALT, 32'h200, 4'h1);
      chk("irq", 48'h0, 48'(irq));
      regRead(REG_STATUS, 32'h5);
      regWrite(REG_MASK, 32'h1);
      regRead(REG_MASK, 32'h1);
      chk("irq", 48'h1, 48'(irq));
      regWrite(REG_STATUS, 32'h1);
      regRead(REG_STATUS, 32'h4);
      chk("irq", 48'h0, 48'(irq));
      regWrite(REG_STATUS, 32'hf);
      $display("test interrupt done");
      enterVleg(2'h3);
      i_src.fire(2, 8'h20, 1'h1, 3);
      #1 chk("hwEvent", 48'h0000_0000_0481, {37'h0, excEvent.valid, excEvent.vec, excEvent.isFault,
         excEvent.taskGate});
      chkMode(VLX_MODE_PROT, PRIV_KERNEL);
      doInstr(VLX_OP_MEM, 32'h180, 4'h0);
      chk("pageEvent", {5'h0, 1'h1, VEC_PAGE, 32'h180, 2'h2}, 48'(excEvent));
      chkMode(VLX_MODE_PROT, PRIV_KERNEL);
      loadFlags(vlImg(2'h3));
      chkMode(VLX_MODE_VLEG, PRIV_USER);
      loadFlags(32'h0000_0002);
      // Task switch keeps the level the old task ran at
      chkMode(VLX_MODE_PROT, PRIV_USER);
      $display("test task switch done");
      enterVleg(2'h3);
      doInstr(VLX_OP_POP_FLAGS_INSTR, 32'h300, 4'h1);
      chkMode(VLX_MODE_VLEG, PRIV_USER);
      regRead(REG_FLAGS, vlImg(2'h3));
      $display("test pop flags done");
      for (int k = 0; k < 2; k++) begin
         enterVleg(2'h3);
         i_src.fire(k, 8'h00, 1'h0, k);
         #1 chkMode(VLX_MODE_REAL, PRIV_KERNEL);
      end
      $display("test restart done");
      report_and_stop();
   end
endmodule

// file: test/vlx_src_model.sv
// Model of the reset, warm-restart and hardware interrupt sources.
// Assumes the bench calls fire() and that requests are taken on sys_clk.
`timescale 1ns/10ps
module vlx_src_model (
   // Clock
   input wire logic sys_clk,
   // Requests
   output logic resetReq,
   output logic warmReq,
   output logic hwIntReq,
   output logic [7:0] hwIntVec,
   output logic hwIntTaskGate
);
   initial begin
      resetReq = 1'h0;
      warmReq = 1'h0;
      hwIntReq = 1'h0;
      hwIntVec = 8'h00;
      hwIntTaskGate = 1'h0;
   end
   // Kind 0 reset, 1 warm restart, 2 interrupt; lag delays the one-cycle request
   task automatic fire(input int kind, input logic [7:0] vec, input logic gate, input int lag);
      @(posedge sys_clk);
      repeat (lag) @(posedge sys_clk);
      resetReq <= (kind == 0);
      warmReq <= (kind == 1);
      hwIntReq <= (kind == 2);
      hwIntVec <= vec;
      hwIntTaskGate <= gate;
      @(posedge sys_clk);
      resetReq <= 1'h0;
      warmReq <= 1'h0;
      hwIntReq <= 1'h0;
      // Idle vector inverted so a stale value is never mistaken for a live one
      hwIntVec <= ~vec;
      hwIntTaskGate <= ~gate;
   endtask
endmodule
